// ==== logic/tcs_pkg.sv ====
// types shared by the timer control block
package tcs_pkg;

  // extended clock source encodings
  typedef enum logic [1:0] {
    TCS_SRC_SECONDARY_OSCILLATOR = 2'b00,
    TCS_SRC_EXT_PIN = 2'b01,
    TCS_SRC_LOW_POWER_RC_OSCILLATOR = 2'b10,
    TCS_SRC_RESERVED = 2'b11
  } tcs_ext_src_type;

  // input prescale encodings
  typedef enum logic [1:0] {
    TCS_PS_DIV1 = 2'b00,
    TCS_PS_DIV8 = 2'b01,
    TCS_PS_DIV64 = 2'b10,
    TCS_PS_DIV256 = 2'b11
  } tcs_prescale_type;

endpackage

// ==== logic/tcs_prescaler.sv ====
// input clock prescaler with 1, 8, 64 or 256 division
`timescale 1ns/1ps
`include "tcs_regs.svh"
module tcs_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic clear,
  input wire tcs_pkg::tcs_prescale_type sel,
  // ticks
  input wire logic tick_in,
  output logic tick_out
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [7:0] limit;

  // terminal count for the selected ratio
  always_comb begin
    unique case (sel)
      tcs_pkg::TCS_PS_DIV1: limit = `TCS_PS_LIMIT_1;
      tcs_pkg::TCS_PS_DIV8: limit = `TCS_PS_LIMIT_8;
      tcs_pkg::TCS_PS_DIV64: limit = `TCS_PS_LIMIT_64;
      tcs_pkg::TCS_PS_DIV256: limit = `TCS_PS_LIMIT_256;
    endcase
  end

  // count input ticks, emit one tick per wrap
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (clear) begin
      cnt_nxt = 8'h00;
    end else if (tick_in) begin
      if (cnt_r >= limit) begin
        cnt_nxt = 8'h00;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  // prescaler state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;

  // an output tick follows an input tick seen at the terminal count
  AST_PS_WRAP: assert property (@(posedge clk) disable iff (reset)
    tick_out |-> ($past(tick_in) && ($past(cnt_r) >= $past(limit)) && !$past(clear)))
    else $error("prescaler tick without terminal count");

endmodule

// ==== logic/tcs_regs.svh ====
// register offsets, field positions, reset values and counts of the timer control block
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH

// byte offsets of the registers
`define TCS_OFF_CTRL 8'h00
`define TCS_OFF_COUNT 8'h04
`define TCS_OFF_STATUS 8'h08

// control register field positions
`define TCS_BIT_STOP_IN_IDLE 13
`define TCS_BIT_ECS_HI 9
`define TCS_BIT_ECS_LO 8
`define TCS_BIT_GATE_EN 6
`define TCS_BIT_PS_HI 5
`define TCS_BIT_PS_LO 4
`define TCS_BIT_EXT_SYNC 2
`define TCS_BIT_CLK_SRC 1

// implemented control bits and reset value
`define TCS_CTRL_MASK 16'h2376
`define TCS_CTRL_RESET 16'h0000
`define TCS_COUNT_RESET 16'h0000

// status register field positions
`define TCS_STAT_HALTED 0
`define TCS_STAT_GATE 1
`define TCS_STAT_EXT_ACTIVE 2
`define TCS_STAT_SYNC_PEND 3

// prescaler terminal counts (divide minus one)
`define TCS_PS_LIMIT_1 8'h00
`define TCS_PS_LIMIT_8 8'h07
`define TCS_PS_LIMIT_64 8'h3f
`define TCS_PS_LIMIT_256 8'hff

// pin bit positions inside the synchroniser vector
`define TCS_PIN_LOW_POWER_RC_OSCILLATOR 0
`define TCS_PIN_EXT 1
`define TCS_PIN_SECONDARY_OSCILLATOR 2
`define TCS_PIN_GATE 3
`define TCS_PIN_COUNT 4

`endif

// ==== logic/tcs_sync2.sv ====
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module tcs_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pin levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

// ==== logic/tcs_timer_ctrl.sv ====
// timer clock source, gating, sync and prescale control with apb registers
`timescale 1ns/1ps
`include "tcs_regs.svh"
module tcs_timer_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock source and gate pins
  input wire logic low_power_rc_oscillator,
  input wire logic external_timer_clock_pin,
  input wire logic secondary_oscillator,
  input wire logic gate_pin,
  // device state
  input wire logic idle_mode,
  // prescaled timer tick
  output logic timer_tick
);

  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [`TCS_PIN_COUNT-1:0] pin_raw;
  logic [`TCS_PIN_COUNT-1:0] pin_q;
  logic [`TCS_PIN_COUNT-1:0] pin_prev_r;
  logic [`TCS_PIN_COUNT-1:0] pin_rise;
  logic int_phase_r;
  logic int_phase_nxt;
  logic int_tick;
  logic pend_r;
  logic pend_nxt;
  logic ext_rise;
  logic ext_tick;
  logic src_tick;
  logic halted;
  logic run_tick;
  logic ps_tick;
  logic ps_clear;
  logic access;
  logic wr_ctrl;
  logic wr_count;
  logic addr_ok;
  logic stop_in_idle;
  tcs_pkg::tcs_ext_src_type extended_clock_select;
  logic gate_accumulate_enable;
  tcs_pkg::tcs_prescale_type input_prescale_select;
  logic external_clock_sync;
  logic clock_source_select;
  logic [15:0] status;

  // control fields
  assign stop_in_idle = ctrl_r[`TCS_BIT_STOP_IN_IDLE];
  assign extended_clock_select = tcs_pkg::tcs_ext_src_type'(ctrl_r[`TCS_BIT_ECS_HI:`TCS_BIT_ECS_LO]);
  assign gate_accumulate_enable = ctrl_r[`TCS_BIT_GATE_EN];
  assign input_prescale_select = tcs_pkg::tcs_prescale_type'(ctrl_r[`TCS_BIT_PS_HI:`TCS_BIT_PS_LO]);
  assign external_clock_sync = ctrl_r[`TCS_BIT_EXT_SYNC];
  assign clock_source_select = ctrl_r[`TCS_BIT_CLK_SRC];

  // apb decode
  assign access = psel && penable && pready_r;
  assign addr_ok = (paddr == `TCS_OFF_CTRL) || (paddr == `TCS_OFF_COUNT) || (paddr == `TCS_OFF_STATUS);
  assign wr_ctrl = access && pwrite && (paddr == `TCS_OFF_CTRL);
  assign wr_count = access && pwrite && (paddr == `TCS_OFF_COUNT);

  // pins from outside pass two flip-flops
  assign pin_raw = {gate_pin, secondary_oscillator, external_timer_clock_pin, low_power_rc_oscillator};

  tcs_sync2 #(
    .WIDTH(`TCS_PIN_COUNT)
  ) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .d(pin_raw),
    .q(pin_q)
  );

  // rising edges of synchronised pins
  assign pin_rise = pin_q & ~pin_prev_r;

  // internal clock tick at half the system rate
  assign int_phase_nxt = ~int_phase_r;
  assign int_tick = int_phase_r;

  // extended source edge
  always_comb begin
    unique case (extended_clock_select)
      tcs_pkg::TCS_SRC_LOW_POWER_RC_OSCILLATOR: ext_rise = pin_rise[`TCS_PIN_LOW_POWER_RC_OSCILLATOR];
      tcs_pkg::TCS_SRC_EXT_PIN: ext_rise = pin_rise[`TCS_PIN_EXT];
      tcs_pkg::TCS_SRC_SECONDARY_OSCILLATOR: ext_rise = pin_rise[`TCS_PIN_SECONDARY_OSCILLATOR];
      tcs_pkg::TCS_SRC_RESERVED: ext_rise = 1'b0;
    endcase
  end

  // optional alignment of external edges to the internal tick
  always_comb begin
    pend_nxt = 1'b0;
    ext_tick = ext_rise;
    if (external_clock_sync) begin
      ext_tick = (pend_r || ext_rise) && int_tick;
      pend_nxt = (pend_r || ext_rise) && !int_tick;
    end
  end

  // source choice, gating and idle halt
  always_comb begin
    if (clock_source_select) begin
      src_tick = ext_tick;
    end else begin
      src_tick = int_tick && (!gate_accumulate_enable || pin_q[`TCS_PIN_GATE]);
    end
    halted = stop_in_idle && idle_mode;
    run_tick = src_tick && !halted;
  end

  // control write restarts the prescaler
  assign ps_clear = wr_ctrl;

  tcs_prescaler u_prescaler (
    .clk(clk),
    .reset(reset),
    .clear(ps_clear),
    .sel(input_prescale_select),
    .tick_in(run_tick),
    .tick_out(ps_tick)
  );

  // status view of block state
  always_comb begin
    status = 16'h0000;
    status[`TCS_STAT_HALTED] = halted;
    status[`TCS_STAT_GATE] = pin_q[`TCS_PIN_GATE];
    status[`TCS_STAT_EXT_ACTIVE] = clock_source_select;
    status[`TCS_STAT_SYNC_PEND] = pend_r;
  end

  // register writes and tick count
  always_comb begin
    ctrl_nxt = ctrl_r;
    count_nxt = count_r;
    if (wr_ctrl) begin
      if (pstrb[0]) begin
        ctrl_nxt[7:0] = pwdata[7:0] & 8'(`TCS_CTRL_MASK);
      end
      if (pstrb[1]) begin
        ctrl_nxt[15:8] = pwdata[15:8] & 8'(`TCS_CTRL_MASK >> 8);
      end
    end
    if (wr_count) begin
      count_nxt = `TCS_COUNT_RESET;
    end
    if (ps_tick) begin
      count_nxt = (wr_count ? `TCS_COUNT_RESET : count_r) + 16'h0001;
    end
  end

  // apb answer, zero wait states
  always_comb begin
    pready_nxt = psel && !penable;
    pslverr_nxt = psel && !penable && !addr_ok;
    prdata_nxt = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `TCS_OFF_CTRL: prdata_nxt = {16'h0000, ctrl_r & `TCS_CTRL_MASK};
        `TCS_OFF_COUNT: prdata_nxt = {16'h0000, count_r};
        `TCS_OFF_STATUS: prdata_nxt = {16'h0000, status};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `TCS_CTRL_RESET;
      count_r <= `TCS_COUNT_RESET;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      pin_prev_r <= '0;
      int_phase_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      count_r <= count_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      pin_prev_r <= pin_q;
      int_phase_r <= int_phase_nxt;
      pend_r <= pend_nxt;
    end
  end

  // outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign timer_tick = ps_tick;

  // checks
  AST_UNIMP_ZERO: assert property (@(posedge clk) disable iff (reset)
    (ctrl_r & ~`TCS_CTRL_MASK) == 16'h0000)
    else $error("unimplemented control bit set");

  AST_IDLE_HALT: assert property (@(posedge clk) disable iff (reset)
    (stop_in_idle && idle_mode) |-> !run_tick)
    else $error("tick while halted in idle");

  AST_IDLE_RUN: assert property (@(posedge clk) disable iff (reset)
    (!stop_in_idle && idle_mode && !clock_source_select && !gate_accumulate_enable && int_tick) |-> run_tick)
    else $error("timer stopped in idle with stop bit clear");

  AST_INT_RATE: assert property (@(posedge clk) disable iff (reset)
    (!clock_source_select && run_tick) |=> !run_tick)
    else $error("internal clock faster than half rate");

  AST_EXT_PIN: assert property (@(posedge clk) disable iff (reset)
    (clock_source_select && !external_clock_sync && !halted
     && extended_clock_select == tcs_pkg::TCS_SRC_EXT_PIN && pin_q[`TCS_PIN_EXT] && !pin_prev_r[`TCS_PIN_EXT])
    |-> run_tick)
    else $error("external pin edge not counted");

  AST_RSVD_SRC: assert property (@(posedge clk) disable iff (reset)
    (clock_source_select && extended_clock_select == tcs_pkg::TCS_SRC_RESERVED && !pend_r) |-> !src_tick)
    else $error("reserved source produced a tick");

  AST_GATE_LOW: assert property (@(posedge clk) disable iff (reset)
    (!clock_source_select && gate_accumulate_enable && !pin_q[`TCS_PIN_GATE]) |-> !src_tick)
    else $error("tick while gate low");

  AST_GATE_IGNORED: assert property (@(posedge clk) disable iff (reset)
    (clock_source_select && ext_tick) |-> src_tick)
    else $error("gate enable blocked extended clock");

  AST_SYNC_ALIGN: assert property (@(posedge clk) disable iff (reset)
    (clock_source_select && external_clock_sync && src_tick) |-> int_tick)
    else $error("synchronised edge off the internal tick");

  AST_SYNC_PEND: assert property (@(posedge clk) disable iff (reset)
    (external_clock_sync && ext_rise && !int_tick) |=> (int_tick && ext_tick))
    else $error("pending external edge not released");

  AST_APB_READY: assert property (@(posedge clk) disable iff (reset)
    (psel && !penable) |=> pready)
    else $error("apb access not answered");

  AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (reset)
    (wr_ctrl && pstrb[1:0] == 2'b11) |=> ctrl_r == ($past(pwdata[15:0]) & `TCS_CTRL_MASK))
    else $error("control write not stored");

  AST_CTRL_READ: assert property (@(posedge clk) disable iff (reset)
    (psel && !penable && !pwrite && paddr == `TCS_OFF_CTRL) |=> (prdata == {16'h0000, $past(ctrl_r) & `TCS_CTRL_MASK}))
    else $error("control readback shows unimplemented bits");

  AST_WRITE_LOCK: assert property (@(posedge clk) disable iff (reset)
    (access && pwrite && paddr != `TCS_OFF_CTRL) |=> $stable(ctrl_r))
    else $error("control changed by a write elsewhere");

  AST_PS_DIV1: assert property (@(posedge clk) disable iff (reset)
    (input_prescale_select == tcs_pkg::TCS_PS_DIV1 && run_tick && !ps_clear) |=> timer_tick)
    else $error("undivided tick not passed on");

  AST_INT_SOURCE: assert property (@(posedge clk) disable iff (reset)
    (!clock_source_select && !gate_accumulate_enable && !halted) |-> (run_tick == int_tick))
    else $error("internal clock not followed");

  AST_EXT_NO_INT: assert property (@(posedge clk) disable iff (reset)
    (clock_source_select && !external_clock_sync && !ext_rise) |-> !src_tick)
    else $error("internal tick leaked into extended source");

  AST_GATE_HIGH: assert property (@(posedge clk) disable iff (reset)
    (!clock_source_select && gate_accumulate_enable && pin_q[`TCS_PIN_GATE] && int_tick && !halted) |-> run_tick)
    else $error("tick lost while gate high");

  AST_SYNC_OFF: assert property (@(posedge clk) disable iff (reset)
    (clock_source_select && !external_clock_sync) |-> (src_tick == ext_rise))
    else $error("unsynchronised edge delayed");

  AST_SLVERR: assert property (@(posedge clk) disable iff (reset)
    (psel && !penable && !addr_ok) |=> pslverr)
    else $error("unmapped access without error");

endmodule

// ==== sim/tcs_timer_ctrl_tb.sv ====
// self-checking bench for the timer clock source and prescale control
`timescale 1ns/1ps
`include "tcs_regs.svh"
module tb;
  // clock, reset and apb
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // pins, device state and bench state
  logic [2:0] pin_run = 3'h0;
  logic [2:0] src_pins = 3'h0;
  logic [2:0] phase = 3'h0;
  logic gate_pin = 1'b0;
  logic idle_mode = 1'b0;
  logic timer_tick;
  logic [31:0] seed = 32'hd9334178;
  logic [31:0] rd;
  logic [31:0] v;
  logic err;
  int failures = 0;
  int compares = 0;
  int gap;
  int cnt;

  tcs_timer_ctrl dut (
    .clk(clk),
    .reset(reset),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .low_power_rc_oscillator(src_pins[`TCS_PIN_LOW_POWER_RC_OSCILLATOR]),
    .external_timer_clock_pin(src_pins[`TCS_PIN_EXT]),
    .secondary_oscillator(src_pins[`TCS_PIN_SECONDARY_OSCILLATOR]),
    .gate_pin(gate_pin),
    .idle_mode(idle_mode),
    .timer_tick(timer_tick)
  );

  // 20 mhz clock
  always #25 clk = ~clk;

  // source pins toggle with a period of eight cycles when running
  always @(posedge clk) begin
    phase <= phase + 3'h1;
    src_pins <= pin_run & {3{phase[2]}};
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // xorshift stimulus source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected control readback
  function automatic logic [31:0] exp_ctrl(input logic [31:0] d);
    return {16'h0000, d[15:0] & `TCS_CTRL_MASK};
  endfunction

  // prescale division per encoding
  function automatic int div_of(input logic [1:0] p);
    case (p)
      2'b00: return 1;
      2'b01: return 8;
      2'b10: return 64;
      default: return 256;
    endcase
  endfunction

  // pin chosen by an extended select value
  function automatic logic [2:0] pin_mask(input logic [1:0] e);
    case (e)
      2'b00: return 3'b100;
      2'b01: return 3'b010;
      default: return 3'b001;
    endcase
  endfunction

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // cycles between two successive ticks
  task automatic tick_gap(output int g);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (timer_tick !== 1'b1 && n < 1200);
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (timer_tick !== 1'b1 && g < 1200);
  endtask

  // ticks seen over a span
  task automatic count_ticks(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      if (timer_tick === 1'b1) c++;
    end
  endtask

  // verdict and end of run
  task automatic complete_run();
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // watchdog
  initial begin
    #(50 * 40000);
    failures++;
    complete_run();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, `TCS_OFF_CTRL, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 24; i++) begin
      v = rnd();
      if (v[9:8] == 2'b11) v[9] = 1'b0;
      apb(1'b1, `TCS_OFF_CTRL, v);
      apb(1'b0, `TCS_OFF_CTRL, 32'h0);
      check(rd, exp_ctrl(v));
    end
    // unmapped address answers with an error
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // every prescale on the internal clock
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, `TCS_OFF_CTRL, {26'h0, p[1:0], 4'h0});
      tick_gap(gap);
      check(gap, 2 * div_of(p[1:0]));
    end
    // internal clock wins while source bit is clear
    pin_run <= 3'h7;
    apb(1'b1, `TCS_OFF_CTRL, 32'h0104);
    tick_gap(gap);
    check(gap, 2);
    pin_run <= 3'h0;
    // idle with and without stop
    idle_mode <= 1'b1;
    apb(1'b1, `TCS_OFF_CTRL, 32'h0);
    tick_gap(gap);
    check(gap, 2);
    idle_mode <= 1'b0;
    apb(1'b1, `TCS_OFF_CTRL, 32'h2000);
    idle_mode <= 1'b1;
    repeat (4) @(posedge clk);
    count_ticks(40, cnt);
    check(cnt, 0);
    apb(1'b0, `TCS_OFF_STATUS, 32'h0);
    check({31'h0, rd[`TCS_STAT_HALTED]}, 32'h1);
    // clear count while halted, run 20 cycles at half rate, halt, read back
    apb(1'b1, `TCS_OFF_COUNT, 32'h0);
    idle_mode <= 1'b0;
    repeat (20) @(posedge clk);
    idle_mode <= 1'b1;
    apb(1'b0, `TCS_OFF_COUNT, 32'h0);
    check(rd, 32'h0000_000a);
    idle_mode <= 1'b0;
    // gated accumulation on the internal clock
    gate_pin <= 1'b0;
    apb(1'b1, `TCS_OFF_CTRL, 32'h0040);
    repeat (4) @(posedge clk);
    count_ticks(40, cnt);
    check(cnt, 0);
    gate_pin <= 1'b1;
    tick_gap(gap);
    check(gap, 2);
    gate_pin <= 1'b0;
    // each extended source, unsynchronised then synchronised, gate low
    for (int s = 0; s < 6; s++) begin
      v = {22'h0, 2'(s % 3), 8'h42} | ((s > 2) ? 32'h4 : 32'h0);
      pin_run <= 3'h7 & ~pin_mask(2'(s % 3));
      apb(1'b1, `TCS_OFF_CTRL, v);
      repeat (4) @(posedge clk);
      count_ticks(40, cnt);
      check(cnt, 0);
      pin_run <= 3'h7;
      tick_gap(gap);
      check(gap, 8);
    end
    pin_run <= 3'h0;
    complete_run();
  end
endmodule
